//--- src/vrc_top.sv
// voltage reference control register bank with axi4-lite access
// assumes one 125 MHz clock and an asynchronous active-low reset
//
// Functional notes
// - setting control bit 7 turns the reference on, clearing it off.
// - the ready flag in bit 6 sets only after the reference has settled.
// - the ready flag reads zero while disabled or still settling.
// - bits 3-2 set the comparator and dac buffer: off, 1x, 2x or 4x.
// - bits 1-0 set the converter buffer: off, 1x, 2x or 4x.
// - the two gain paths are set independently of each other.
// - bit 5 turns the temperature indicator on while one.
// - bit 4 picks the high range when one, the low range when zero.
// - all writable control bits reset to zero; ready is read-only.
// - on the always-ready variant the ready flag reads one always.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
module vrc_top
  import vrc_pkg::*;
#(
  parameter logic ALWAYS_READY = 1'b0
)(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire vrc_axi_req_t axi_req_in,
  output vrc_axi_rsp_t axi_rsp_out,
  output vrc_analog_t analog_out,
  output logic irq_out
);
  typedef struct packed {
    logic [7:0] control;
    logic [1:0] status;
    logic [1:0] mask;
    logic ready_q;
    vrc_analog_t analog;
    logic irq;
  } vrc_top_state_t;

  vrc_top_state_t state_ff;
  vrc_top_state_t nxt_state;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;
  logic settle_ready;
  logic ready_flag;
  logic [7:0] control_view;
  logic [1:0] events;

  vrc_axi_slave u_axi (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .axi_req_in(axi_req_in),
    .axi_rsp_out(axi_rsp_out),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .rd_en_out(rd_en),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_err_in(rd_err),
    .wr_err_in(wr_err)
  );

  vrc_settle u_settle (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .enable_in(state_ff.control[BIT_ENABLE]),
    .ready_out(settle_ready)
  );

  assign ready_flag = ALWAYS_READY | settle_ready;

  always_comb begin
    control_view = state_ff.control;
    control_view[BIT_READY] = ready_flag;
  end

  // ready edges feed the sticky status bits
  assign events[EVT_READY_RISE] = ready_flag && !state_ff.ready_q;
  assign events[EVT_READY_FALL] = !ready_flag && state_ff.ready_q;

  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    case (rd_addr)
      ADDR_CONTROL: rd_data = {24'h0, control_view};
      ADDR_STATUS: rd_data = {30'h0, state_ff.status};
      ADDR_MASK: rd_data = {30'h0, state_ff.mask};
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    case (wr_addr)
      ADDR_CONTROL: wr_err = 1'b0;
      ADDR_STATUS: wr_err = 1'b0;
      ADDR_MASK: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.ready_q = ready_flag;
    if (wr_en && wr_strb[0] && wr_addr == ADDR_CONTROL) begin
      // ready bit is not writable
      nxt_state.control = wr_data[7:0];
      nxt_state.control[BIT_READY] = 1'b0;
    end
    if (wr_en && wr_strb[0] && wr_addr == ADDR_MASK) begin
      nxt_state.mask = wr_data[1:0];
    end
    // read clears status; a new event in the same cycle wins
    if (rd_en && rd_addr == ADDR_STATUS) begin
      nxt_state.status = 2'h0;
    end
    nxt_state.status = nxt_state.status | events;
    nxt_state.analog.ref_on = state_ff.control[BIT_ENABLE];
    nxt_state.analog.temp_on = state_ff.control[BIT_TEMP_EN];
    nxt_state.analog.temp_high_range =
      state_ff.control[BIT_TEMP_RNG];
    nxt_state.analog.cmp_gain_onehot = vrc_gain_decode(
      state_ff.control[BIT_CMP_GAIN +: 2]);
    nxt_state.analog.adc_gain_onehot = vrc_gain_decode(
      state_ff.control[BIT_ADC_GAIN +: 2]);
    nxt_state.irq = |(state_ff.status & state_ff.mask);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff.control <= CONTROL_RESET;
      state_ff.status <= STATUS_RESET;
      state_ff.mask <= MASK_RESET;
      state_ff.ready_q <= 1'b0;
      state_ff.analog <= '0;
      state_ff.irq <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign analog_out = state_ff.analog;
  assign irq_out = state_ff.irq;
endmodule

//--- inc/vrc_pkg.sv
// package for the voltage reference control block
// assumes a 125 MHz system clock and an axi4-lite register bus
package vrc_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  // control field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_READY = 6;
  localparam int BIT_TEMP_EN = 5;
  localparam int BIT_TEMP_RNG = 4;
  localparam int BIT_CMP_GAIN = 2;
  localparam int BIT_ADC_GAIN = 0;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // status bit positions
  localparam int EVT_READY_RISE = 0;
  localparam int EVT_READY_FALL = 1;
  // settle timing
  localparam int SETTLE_TIME_NS = 25000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int SETTLE_WIDTH = 16;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GAIN_OFF = 2'h0,
    GAIN_1X = 2'h1,
    GAIN_2X = 2'h2,
    GAIN_4X = 2'h3
  } vrc_gain_t;

  typedef struct packed {
    logic ref_on;
    logic temp_on;
    logic temp_high_range;
    logic [2:0] cmp_gain_onehot;
    logic [2:0] adc_gain_onehot;
  } vrc_analog_t;

  typedef struct packed {
    logic [3:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [3:0] araddr;
    logic arvalid;
    logic rready;
  } vrc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } vrc_axi_rsp_t;

  // gain field to one-hot buffer setting, off gives all zero
  function automatic logic [2:0] vrc_gain_decode(input logic [1:0] sel);
    logic [2:0] res;
    res = 3'h0;
    case (sel)
      GAIN_1X: res = 3'h1;
      GAIN_2X: res = 3'h2;
      GAIN_4X: res = 3'h4;
      default: res = 3'h0;
    endcase
    return res;
  endfunction
endpackage

//--- src/vrc_settle.sv
// settle counter for the fixed reference
// assumes enable comes from logic on the same clock
module vrc_settle
  import vrc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  output logic ready_out
);
  typedef struct packed {
    logic [SETTLE_WIDTH-1:0] count;
    logic ready;
  } vrc_settle_state_t;

  vrc_settle_state_t state_ff;
  vrc_settle_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (!enable_in) begin
      nxt_state.count = '0;
      nxt_state.ready = 1'b0;
    end else if (state_ff.count ==
                 SETTLE_WIDTH'(SETTLE_CYCLES - 1)) begin
      nxt_state.ready = 1'b1;
    end else begin
      nxt_state.count = state_ff.count + SETTLE_WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ready_out = state_ff.ready;
endmodule

//--- src/vrc_axi_slave.sv
// axi4-lite slave front end, one write and one read at a time
// assumes the register core answers reads in the same cycle
module vrc_axi_slave
  import vrc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire vrc_axi_req_t axi_req_in,
  output vrc_axi_rsp_t axi_rsp_out,
  output logic wr_en_out,
  output logic [3:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  output logic rd_en_out,
  output logic [3:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_err_in,
  input wire logic wr_err_in
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vrc_axi_state_t;

  vrc_axi_state_t state_ff;
  vrc_axi_state_t nxt_state;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;

  assign aw_take = axi_req_in.awvalid && !state_ff.aw_got
                   && !state_ff.bvalid;
  assign w_take = axi_req_in.wvalid && !state_ff.w_got && !state_ff.bvalid;
  assign ar_take = axi_req_in.arvalid && !state_ff.rvalid;
  assign do_write = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;

  always_comb begin
    nxt_state = state_ff;
    if (aw_take) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.awaddr = axi_req_in.awaddr;
    end
    if (w_take) begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = axi_req_in.wdata;
      nxt_state.wstrb = axi_req_in.wstrb;
    end
    if (do_write) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = wr_err_in ? RESP_SLVERR : RESP_OKAY;
    end else if (state_ff.bvalid && axi_req_in.bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = rd_data_in;
      nxt_state.rresp = rd_err_in ? RESP_SLVERR : RESP_OKAY;
    end else if (state_ff.rvalid && axi_req_in.rready) begin
      nxt_state.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wr_en_out = do_write;
  assign wr_addr_out = state_ff.awaddr;
  assign wr_data_out = state_ff.wdata;
  assign wr_strb_out = state_ff.wstrb;
  assign rd_en_out = ar_take;
  assign rd_addr_out = axi_req_in.araddr;

  always_comb begin
    axi_rsp_out.awready = aw_take;
    axi_rsp_out.wready = w_take;
    axi_rsp_out.bvalid = state_ff.bvalid;
    axi_rsp_out.bresp = state_ff.bresp;
    axi_rsp_out.arready = ar_take;
    axi_rsp_out.rvalid = state_ff.rvalid;
    axi_rsp_out.rdata = state_ff.rdata;
    axi_rsp_out.rresp = state_ff.rresp;
  end
endmodule

//--- test/vrc_top_sva.sv
// port checker for the reference control block
// assumes one clock and an async active-low reset
module vrc_top_sva
  import vrc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire vrc_axi_req_t axi_req_in,
  input wire vrc_axi_rsp_t axi_rsp_out,
  input wire vrc_analog_t analog_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_ON = SETTLE_CYCLES - 2;
  logic [12:0] on_ff;
  logic [12:0] nxt_on;
  // cycles since the reference came on, saturating
  always_comb begin
    nxt_on = on_ff + 13'h1;
    if (!analog_out.ref_on) nxt_on = 13'h0;
    else if (&on_ff) nxt_on = on_ff;
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) on_ff <= 13'h0;
    else on_ff <= nxt_on;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  sequence s_b_wait;
    axi_rsp_out.bvalid && !axi_req_in.bready;
  endsequence
  sequence s_r_wait;
    axi_rsp_out.rvalid && !axi_req_in.rready;
  endsequence
  a_cmp_gain_code: assert property (
    $onehot0(analog_out.cmp_gain_onehot)) else $error("cmp gain code");
  a_adc_gain_code: assert property (
    $onehot0(analog_out.adc_gain_onehot)) else $error("adc gain code");
  a_reset_quiet: assert property (
    $rose(resetn_in) |-> analog_out == '0 && !irq_out)
    else $error("outputs not clear after reset");
  a_analog_from_write: assert property (
    $changed(analog_out) |-> $past(axi_rsp_out.bvalid))
    else $error("analog changed without write");
  a_ready_not_early: assert property (
    $rose(irq_out) && analog_out.ref_on |-> on_ff >= MIN_ON)
    else $error("ready before settle");
  a_bresp_hold: assert property (
    s_b_wait |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_r_wait |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
    else $error("read data dropped");
  a_no_write_take: assert property (
    axi_rsp_out.bvalid |-> !axi_rsp_out.awready && !axi_rsp_out.wready)
    else $error("write taken while busy");
  a_no_read_take: assert property (
    axi_rsp_out.rvalid |-> !axi_rsp_out.arready)
    else $error("read taken while busy");
endmodule

//--- test/vrc_top_tb.sv
// bench for the reference control block over axi4-lite
// assumes 8 ns clock; second instance is the always-ready variant
module vrc_top_tb
  import vrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in;
  logic resetn_in;
  vrc_axi_req_t req;
  vrc_axi_rsp_t rsp;
  vrc_axi_rsp_t rsp2;
  vrc_analog_t ana;
  logic irq;
  logic [31:0] last2;
  logic [1:0] gs;
  int n_errors;
  int n_tests;
  vrc_top i_vrc_top (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .axi_req_in(req), .axi_rsp_out(rsp), .analog_out(ana), .irq_out(irq));
  vrc_top #(.ALWAYS_READY(1'b1)) i_vrc_top_rdy (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .axi_req_in(req), .axi_rsp_out(rsp2),
    .analog_out(), .irq_out());
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [2:0] oh(input logic [1:0] g);
    return (g == 2'h0) ? 3'h0 : 3'h1 << (g - 2'h1);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    int i;
    @(posedge clk_sys_in);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid) break;
      if (rsp.bvalid) req.bready <= 1'b1;
    end
    if (i == 64) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, 32'h0, 32'h1);
    end
    req.bready <= 1'b0;
    chk({30'h0, rsp.bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    int i;
    @(posedge clk_sys_in);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid) break;
      if (rsp.rvalid) req.rready <= 1'b1;
    end
    if (i == 64) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, 32'h0, 32'h1);
    end
    req.rready <= 1'b0;
    last2 = rsp2.rdata;
    chk(rsp.rdata, {24'h0, e});
    chk({30'h0, rsp.rresp}, {30'h0, er});
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    $display("FAIL %0t got %h exp %h", $time, 32'h0, 32'h1);
    end_sim();
  end
  initial begin
    resetn_in = 1'b0;
    req = '0;
    req.wstrb = 4'hf;
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    chk({23'h0, ana}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_CONTROL, 8'h00, RESP_OKAY);
    chk(last2, 32'h40);
    rd(ADDR_MASK, 8'h00, RESP_OKAY);
    rd(ADDR_STATUS, 8'h00, RESP_OKAY);
    // every gain code on both paths, temp bits in all four states
    for (int g = 0; g < 4; g++) begin
      gs = g[1:0];
      wr(ADDR_CONTROL, {2'b00, gs[0], gs[1], gs, ~gs}, RESP_OKAY);
      @(posedge clk_sys_in);
      chk({23'h0, ana}, {24'h0, gs[0], gs[1], oh(gs), oh(~gs)});
    end
    wr(ADDR_CONTROL, 8'h40, RESP_OKAY);
    rd(ADDR_CONTROL, 8'h00, RESP_OKAY);
    // low strobe bit off: the write must leave control alone
    req.wstrb <= 4'he;
    wr(ADDR_CONTROL, 8'h3f, RESP_OKAY);
    req.wstrb <= 4'hf;
    rd(ADDR_CONTROL, 8'h00, RESP_OKAY);
    wr(4'hc, 8'hff, RESP_SLVERR);
    rd(4'hc, 8'h00, RESP_SLVERR);
    wr(ADDR_MASK, 8'h01, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h80, RESP_OKAY);
    rd(ADDR_CONTROL, 8'h80, RESP_OKAY);
    chk({31'h0, ana.ref_on}, 32'h1);
    repeat (3000) @(posedge clk_sys_in);
    rd(ADDR_CONTROL, 8'h80, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    repeat (200) @(posedge clk_sys_in);
    rd(ADDR_CONTROL, 8'hc0, RESP_OKAY);
    chk(last2, 32'hc0);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_STATUS, 8'h01, RESP_OKAY);
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    rd(ADDR_CONTROL, 8'h00, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_STATUS, 8'h02, RESP_OKAY);
    // second reset in mid-run with every writable bit set
    wr(ADDR_CONTROL, 8'hbf, RESP_OKAY);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    chk({23'h0, ana}, 32'h0);
    rd(ADDR_CONTROL, 8'h00, RESP_OKAY);
    chk(last2, 32'h40);
    rd(ADDR_MASK, 8'h00, RESP_OKAY);
    rd(ADDR_STATUS, 8'h00, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    end_sim();
  end
endmodule
bind vrc_top vrc_top_sva i_vrc_top_sva (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .axi_req_in(axi_req_in),
  .axi_rsp_out(axi_rsp_out), .analog_out(analog_out), .irq_out(irq_out));
